// ==== rtl/fcss_pkg.sv ====
// holds the shared constants and types of the four channel sampling sequencer
// assumes a single 25 MHz conversion clock and a synchronous active high reset
`default_nettype none

package fcss_pkg;
	// ****************************************
	// widths and counts
	// ****************************************
	localparam int CH_NUM = 4;
	localparam int CH_W = 2;
	localparam int RES_W = 12;
	localparam int IDX_W = 4;
	localparam int CNT_W = 5;
	localparam logic [IDX_W-1:0] IDX_TOP = 4'hb;
	localparam logic [RES_W-1:0] SAR_MID = 12'h800;
	localparam logic [RES_W-1:0] RES_RST = 12'h000;
	localparam logic [CH_W-1:0] CH_FIRST = 2'h0;
	localparam logic [CH_W-1:0] CH_LAST = 2'h3;

	// ****************************************
	// sequence timing
	// ****************************************
	localparam int SEQ_EDGES = 78;
	localparam int SYNC_EDGES = 2;
	localparam int CH_CYCLES = (SEQ_EDGES - SYNC_EDGES) / CH_NUM;
	localparam logic [CNT_W-1:0] CNT_FIRST_BIT = 5'h01;
	localparam logic [CNT_W-1:0] CNT_STORE = 5'h0d;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CH_CYCLES - 1);
	localparam int CLK_HZ = 25_000_000;
	// time bound holds at the rated 2.5 MHz clock, so it is counted in those edges
	localparam int RATED_CLK_KHZ = 2500;
	localparam int CONV_MAX_NS = 32500;
	localparam int CONV_MAX_CYC = CONV_MAX_NS * RATED_CLK_KHZ / 1_000_000;

	typedef enum logic {ST_IDLE, ST_CONV} fcss_state_t;
endpackage : fcss_pkg

`default_nettype wire

// ==== rtl/fcss_sar_if.sv ====
// holds the link between the sequencer and its approximation register
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface fcss_sar_if;
	logic init;
	logic step;
	logic comp;
	logic [fcss_pkg::RES_W-1:0] trial;
	logic [fcss_pkg::RES_W-1:0] result;
	modport seq (output init, output step, output comp, input trial, input result);
	modport sar (input init, input step, input comp, output trial, output result);
endinterface : fcss_sar_if

`default_nettype wire

// ==== rtl/fcss_sar.sv ====
// holds the successive approximation register with two's complement output
// assumes the comparator answer is settled one cycle after each trial code
`timescale 1ns/100ps
`default_nettype none

module fcss_sar (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	fcss_sar_if.sar sar
);
	logic [fcss_pkg::RES_W-1:0] trial_reg;
	logic [fcss_pkg::RES_W-1:0] trial_next;
	logic [fcss_pkg::IDX_W-1:0] idx_reg;
	logic [fcss_pkg::IDX_W-1:0] idx_next;

	always_comb begin
		trial_next = trial_reg;
		idx_next = idx_reg;
		if (sar.init) begin
			trial_next = fcss_pkg::SAR_MID;
			idx_next = fcss_pkg::IDX_TOP;
		end else if (sar.step) begin
			trial_next[idx_reg] = sar.comp;
			if (idx_reg != '0) begin
				trial_next[idx_reg - 4'h1] = 1'b1;
				idx_next = idx_reg - 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			trial_reg <= fcss_pkg::RES_RST;
			idx_reg <= '0;
		end else if (clk_en_i) begin
			trial_reg <= trial_next;
			idx_reg <= idx_next;
		end
	end

	assign sar.trial = trial_reg;
	// offset binary trial flipped at msb gives two's complement, lsb = fs/4096
	assign sar.result = {~trial_reg[fcss_pkg::RES_W-1], trial_reg[fcss_pkg::RES_W-2:0]}; // see RULE14 see RULE15

	a_twos_code: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE15
		sar.trial == 12'h000 || sar.trial == 12'hfff
		|-> sar.result == (sar.trial[0] ? 12'h7ff : 12'h800))
		else $error("end codes not in two's complement");
	a_sar_init: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE14
		sar.init && clk_en_i |=> sar.trial == fcss_pkg::SAR_MID)
		else $error("trial not at midscale after init");
endmodule : fcss_sar

`default_nettype wire

// ==== rtl/fcss_top.sv ====
// holds the four channel sampling sequencer and its implicit read port
// assumes trigger, read strobe and select are pins asynchronous to clk_i
// What this block does
// (RULE1) trigger rising edge starts the sequence and puts all holds into hold
// (RULE2) all four holds stay in hold until every channel is converted
// (RULE3) channels convert in order 1 to 4, each into its own result register
// (RULE4) next channel starts only after the previous result is stored
// (RULE5) done flag goes low after channel 4 result is stored
// (RULE6) whole sequence takes 78 or 79 rising clock edges
// (RULE7) trigger to done takes at most 32.5 us at a 2.5 MHz clock
// (RULE8) trigger is accepted asynchronously, independent of other bus controls
// (RULE9) repeated reads at one address return the four results in turn
// (RULE10) no direct access to a chosen result register exists
// (RULE11) first read returns channel 1, then 2, 3 and 4
// (RULE12) done flag returns high at the start of the first read after conversion
// (RULE13) each trigger rising edge resets the read pointer to channel 1
// (RULE14) results are 12 bit two's complement, step is full scale over 4096
// (RULE15) most negative is 800 hex, most positive 7ff hex
// (RULE16) host must not retrigger before all four channels are done
// (RULE17) host must not read while a sequence runs
// (RULE18) host should gate its trigger decode with a bus strobe
// (RULE19) result bus driven only while read strobe and select are both low
// (RULE20) conversion runs from external clock or internal oscillator
// (RULE21) bus floats outside reads; pointer advances at the end of each read
// (RULE22) trigger edge is synchronised before the sequencer acts on it
`timescale 1ns/100ps
`default_nettype none

module fcss_top (
	input wire logic clk_i, // external or internal oscillator, muxed outside; see RULE20
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic sample_trigger_i,
	input wire logic rd_n_i,
	input wire logic cs_n_i,
	input wire logic comp_i,
	output logic [fcss_pkg::CH_NUM-1:0] hold_o,
	output logic [fcss_pkg::CH_W-1:0] mux_sel_o,
	output logic [fcss_pkg::RES_W-1:0] dac_code_o,
	output logic done_n_o,
	output logic [fcss_pkg::RES_W-1:0] result_bus_o,
	output logic result_bus_oe_n_o
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] trig_sync_reg;
	logic [2:0] trig_sync_next;
	logic [1:0] rd_sync_reg;
	logic [1:0] rd_sync_next;
	logic [1:0] cs_sync_reg;
	logic [1:0] cs_sync_next;
	logic trig_rise;
	logic read_act;
	logic read_prev_reg;
	logic read_prev_next;
	logic read_start;
	logic read_end;

	always_comb begin
		trig_sync_next = {trig_sync_reg[1:0], sample_trigger_i};
		rd_sync_next = {rd_sync_reg[0], rd_n_i};
		cs_sync_next = {cs_sync_reg[0], cs_n_i};
		read_prev_next = read_act;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			trig_sync_reg <= 3'h0;
			rd_sync_reg <= 2'h3;
			cs_sync_reg <= 2'h3;
			read_prev_reg <= 1'b0;
		end else if (clk_en_i) begin
			trig_sync_reg <= trig_sync_next; // see RULE8 see RULE22
			rd_sync_reg <= rd_sync_next;
			cs_sync_reg <= cs_sync_next;
			read_prev_reg <= read_prev_next;
		end
	end

	// edge seen on the second and third stages only, first stage may be metastable
	assign trig_rise = trig_sync_reg[1] && !trig_sync_reg[2]; // see RULE22
	assign read_act = !rd_sync_reg[1] && !cs_sync_reg[1]; // see RULE19
	// both edges come from one registered copy of read_act, so a strobe
	// and select released together still end the read
	assign read_start = read_act && !read_prev_reg;
	assign read_end = !read_act && read_prev_reg;

	// ****************************************
	// conversion sequencer
	// ****************************************
	fcss_sar_if sar_link ();
	fcss_pkg::fcss_state_t state_reg;
	fcss_pkg::fcss_state_t state_next;
	logic [fcss_pkg::CH_W-1:0] ch_reg;
	logic [fcss_pkg::CH_W-1:0] ch_next;
	logic [fcss_pkg::CNT_W-1:0] cnt_reg;
	logic [fcss_pkg::CNT_W-1:0] cnt_next;
	logic done_n_reg;
	logic done_n_next;
	logic store;
	logic [fcss_pkg::RES_W-1:0] res_reg [fcss_pkg::CH_NUM];
	logic [fcss_pkg::RES_W-1:0] res_next [fcss_pkg::CH_NUM];

	assign store = state_reg == fcss_pkg::ST_CONV && cnt_reg == fcss_pkg::CNT_STORE;
	assign sar_link.init = state_reg == fcss_pkg::ST_CONV && cnt_reg == '0;
	assign sar_link.step = state_reg == fcss_pkg::ST_CONV && cnt_reg >= fcss_pkg::CNT_FIRST_BIT
		&& cnt_reg < fcss_pkg::CNT_STORE;
	assign sar_link.comp = comp_i;

	always_comb begin
		state_next = state_reg;
		ch_next = ch_reg;
		cnt_next = cnt_reg;
		done_n_next = done_n_reg;
		if (read_start && !done_n_reg) begin
			done_n_next = 1'b1; // see RULE12
		end
		unique case (state_reg)
			fcss_pkg::ST_IDLE: begin
				// retrigger during a sequence is ignored, the host must wait
				if (trig_rise) begin // see RULE1 see RULE16
					state_next = fcss_pkg::ST_CONV;
					ch_next = fcss_pkg::CH_FIRST;
					cnt_next = '0;
					done_n_next = 1'b1;
				end
			end
			fcss_pkg::ST_CONV: begin
				if (cnt_reg != fcss_pkg::CNT_LAST) begin
					cnt_next = cnt_reg + 5'h01;
				end else if (ch_reg != fcss_pkg::CH_LAST) begin
					// next channel only after the store slot has passed
					cnt_next = '0; // see RULE4
					ch_next = ch_reg + 2'h1; // see RULE3
				end else begin
					state_next = fcss_pkg::ST_IDLE;
					done_n_next = 1'b0; // see RULE5 see RULE6 see RULE7
				end
			end
		endcase
	end

	for (genvar g = 0; g < fcss_pkg::CH_NUM; g++) begin : g_res
		always_comb begin
			res_next[g] = res_reg[g];
			if (store && ch_reg == fcss_pkg::CH_W'(g)) begin
				res_next[g] = sar_link.result; // see RULE3
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= fcss_pkg::ST_IDLE;
			ch_reg <= fcss_pkg::CH_FIRST;
			cnt_reg <= '0;
			done_n_reg <= 1'b1;
			for (int i = 0; i < fcss_pkg::CH_NUM; i++) begin
				res_reg[i] <= fcss_pkg::RES_RST;
			end
		end else if (clk_en_i) begin
			state_reg <= state_next;
			ch_reg <= ch_next;
			cnt_reg <= cnt_next;
			done_n_reg <= done_n_next;
			res_reg <= res_next;
		end
	end

	fcss_sar u_sar (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.sar(sar_link.sar)
	);

	// ****************************************
	// implicit read port
	// ****************************************
	logic [fcss_pkg::CH_W-1:0] ptr_reg;
	logic [fcss_pkg::CH_W-1:0] ptr_next;
	logic [fcss_pkg::RES_W-1:0] bus_reg;
	logic [fcss_pkg::RES_W-1:0] bus_next;
	logic oe_n_reg;
	logic oe_n_next;

	always_comb begin
		ptr_next = ptr_reg;
		if (trig_rise) begin
			ptr_next = fcss_pkg::CH_FIRST; // see RULE13
		end else if (read_end) begin
			ptr_next = ptr_reg + 2'h1; // see RULE21
		end
		// only the pointer selects a register, there is no address path
		bus_next = res_reg[ptr_reg]; // see RULE9 see RULE10 see RULE11
		oe_n_next = !read_act; // see RULE19 see RULE21
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ptr_reg <= fcss_pkg::CH_FIRST;
			bus_reg <= fcss_pkg::RES_RST;
			oe_n_reg <= 1'b1;
		end else if (clk_en_i) begin
			ptr_reg <= ptr_next;
			bus_reg <= bus_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// raw pin joins the hold so sampling follows the pin edge, not the clock
	assign hold_o = {fcss_pkg::CH_NUM{state_reg == fcss_pkg::ST_CONV || sample_trigger_i}}; // see RULE1 see RULE2 see RULE22
	assign mux_sel_o = ch_reg;
	assign dac_code_o = sar_link.trial;
	assign done_n_o = done_n_reg;
	assign result_bus_o = bus_reg;
	assign result_bus_oe_n_o = oe_n_reg;

	// ****************************************
	// checks
	// ****************************************
	localparam int DONE_LAT = 77;
	localparam int CONV_MAX = fcss_pkg::CONV_MAX_CYC;

	sequence s_trig;
		trig_rise && state_reg == fcss_pkg::ST_IDLE;
	endsequence
	sequence s_done;
		$fell(done_n_reg);
	endsequence

	a_hold_all: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE2
		state_reg == fcss_pkg::ST_CONV |-> hold_o == 4'hf)
		else $error("a hold released during conversion");
	a_seq_start: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE1
		s_trig |=> state_reg == fcss_pkg::ST_CONV && ch_reg == fcss_pkg::CH_FIRST && cnt_reg == '0)
		else $error("trigger did not start channel 1");
	a_seq_length: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE6
		s_trig |-> ##DONE_LAT s_done)
		else $error("done flag not at fixed sequence length");
	a_conv_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE7
		s_trig |-> ##[1:CONV_MAX] !done_n_reg)
		else $error("conversion exceeded maximum time");
	a_ch_order: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE3
		state_reg == fcss_pkg::ST_CONV && cnt_reg == fcss_pkg::CNT_LAST && ch_reg != fcss_pkg::CH_LAST
		|=> ch_reg == $past(ch_reg) + 2'h1 && cnt_reg == '0)
		else $error("channel order broken");
	a_store_val: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE4
		store |=> res_reg[$past(ch_reg)] == $past(sar_link.result))
		else $error("result not stored for current channel");
	a_done_after4: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE5
		s_done |-> $past(store, fcss_pkg::CH_CYCLES - 13) && $past(ch_reg) == fcss_pkg::CH_LAST)
		else $error("done fell without channel 4 stored");
	a_done_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE12
		read_start && !done_n_reg && !trig_rise |=> done_n_reg)
		else $error("done flag not cleared by first read");
	a_ptr_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE13
		trig_rise |=> ptr_reg == fcss_pkg::CH_FIRST)
		else $error("pointer not reset by trigger");
	a_ptr_adv: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE21
		read_end && !trig_rise |=> ptr_reg == $past(ptr_reg) + 2'h1)
		else $error("pointer did not advance after read");
	a_bus_float: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE19
		!read_act |=> result_bus_oe_n_o)
		else $error("result bus driven outside a read");
	a_bus_data: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i) // see RULE11
		read_act |=> result_bus_o == res_reg[$past(ptr_reg)])
		else $error("bus shows wrong result register");
endmodule : fcss_top

`default_nettype wire

// ==== dv/fcss_afe_model.sv ====
// holds a behavioural model of the four track/holds and the comparator
// assumes dac_code_i is offset binary and comp_o is read one cycle later
`timescale 1ns/100ps
`default_nettype none

module fcss_afe_model (
	input wire logic [3:0] hold_i,
	input wire logic [1:0] mux_sel_i,
	input wire logic [11:0] dac_code_i,
	input wire logic [47:0] vin_i,
	output logic comp_o
);
	// ****************************************
	// track/hold and comparator
	// ****************************************
	logic [47:0] held;

	// each stage tracks while low, freezes while high
	always @(vin_i or hold_i) begin
		for (int k = 0; k < 4; k++) begin
			if (!hold_i[k]) begin
				held[k*12 +: 12] = vin_i[k*12 +: 12];
			end
		end
	end

	// input sits half a step above its code, so >= keeps the bit
	assign comp_o = (held[mux_sel_i*12 +: 12] >= dac_code_i);
endmodule : fcss_afe_model

`default_nettype wire

// ==== dv/test_four_channel_sampling_sequencer.sv ====
// holds the self-checking bench of the four channel sampling sequencer
// assumes the design files and dv/fcss_afe_model.sv are compiled first
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module test_four_channel_sampling_sequencer;
	// ****************************************
	// clock, reset, design and model
	// ****************************************
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic sample_trigger_i = 1'b0;
	logic rd_n_i = 1'b1;
	logic cs_n_i = 1'b1;
	logic comp_i;
	logic [47:0] vin = 48'h0;
	logic [3:0] hold_o;
	logic [1:0] mux_sel_o;
	logic [11:0] dac_code_o;
	logic done_n_o;
	logic [11:0] result_bus_o;
	logic result_bus_oe_n_o;
	int error_cnt = 0;
	int num_checks = 0;

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	fcss_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
		.sample_trigger_i(sample_trigger_i), .rd_n_i(rd_n_i), .cs_n_i(cs_n_i),
		.comp_i(comp_i), .hold_o(hold_o), .mux_sel_o(mux_sel_o), .dac_code_o(dac_code_o),
		.done_n_o(done_n_o), .result_bus_o(result_bus_o),
		.result_bus_oe_n_o(result_bus_oe_n_o));

	fcss_afe_model afe (.hold_i(hold_o), .mux_sel_i(mux_sel_o), .dac_code_i(dac_code_o),
		.vin_i(vin), .comp_o(comp_i));

	// ****************************************
	// tasks
	// ****************************************
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// inputs change after hold so a leaky hold gives wrong codes
	// frz > 0 drops the clock enable for frz edges while bits resolve
	task convert(input logic [47:0] v, input int frz);
		int cnt;
		logic [7:0] seq;
		logic [1:0] last;
		logic [11:0] code;
		vin <= v;
		@(posedge clk_i);
		sample_trigger_i <= 1'b1;
		#1;
		`CHK(hold_o, 4'hf)
		vin <= ~v;
		last = mux_sel_o;
		seq = {6'h00, mux_sel_o};
		code = 12'h000;
		for (cnt = 1; cnt <= 900; cnt++) begin
			@(posedge clk_i);
			if (cnt == 4) sample_trigger_i <= 1'b0;
			if (frz > 0 && cnt == 8) clk_en_i <= 1'b0;
			if (frz > 0 && cnt == 8 + frz) clk_en_i <= 1'b1;
			#1;
			if (done_n_o === 1'b0) break;
			`CHK(hold_o, 4'hf)
			if (cnt == 8) code = dac_code_o;
			if (cnt > 8 && cnt <= 8 + frz) begin
				`CHK(dac_code_o, code)
			end
			if (mux_sel_o !== last) begin
				seq = {seq[5:0], mux_sel_o};
				last = mux_sel_o;
			end
		end
		if (cnt > 900) begin
			error_cnt++;
			end_sim();
		end
		`CHK(cnt - frz == 78 || cnt - frz == 79, 1'b1)
		`CHK(cnt - frz <= fcss_pkg::CONV_MAX_CYC, 1'b1)
		`CHK(seq, 8'h1b)
		`CHK(done_n_o, 1'b0)
	endtask : convert

	// strobes stay at least three cycles low and three high
	task rd(input logic cs, input logic [11:0] exp);
		int i;
		`CHK(result_bus_oe_n_o, 1'b1)
		@(posedge clk_i);
		rd_n_i <= 1'b0;
		cs_n_i <= cs;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_i);
			#1;
			if (result_bus_oe_n_o === 1'b0) break;
		end
		if (cs) begin
			`CHK(result_bus_oe_n_o, 1'b1)
		end else begin
			`CHK(result_bus_oe_n_o, 1'b0)
			`CHK(result_bus_o, exp)
			`CHK(done_n_o, 1'b1)
		end
		if (!cs && i == 8) end_sim();
		@(posedge clk_i);
		rd_n_i <= 1'b1;
		cs_n_i <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_i);
			#1;
			if (result_bus_oe_n_o === 1'b1) break;
		end
		`CHK(result_bus_oe_n_o, 1'b1)
		if (i == 8) end_sim();
		repeat (3) @(posedge clk_i);
	endtask : rd

	// expected code is the offset binary input with its top bit turned
	task read_from(input logic [47:0] v, input int first, input int n);
		for (int k = first; k < first + n; k++) begin
			rd(1'b0, v[(k%4)*12 +: 12] ^ 12'h800);
		end
	endtask : read_from

	task t_extremes;
		convert(48'h800_7ff_fff_000, 0);
		read_from(48'h800_7ff_fff_000, 0, 4);
		$display("test extremes done");
	endtask : t_extremes

	task t_pointer;
		convert(48'h9de_456_abc_123, 10);
		rd(1'b1, 12'h000);
		`CHK(done_n_o, 1'b0)
		read_from(48'h9de_456_abc_123, 0, 2);
		convert(48'h321_654_987_cba, 0);
		read_from(48'h321_654_987_cba, 0, 5);
		$display("test pointer done");
	endtask : t_pointer

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1;
		`CHK(done_n_o, 1'b1)
		`CHK(result_bus_oe_n_o, 1'b1)
		`CHK(mux_sel_o, 2'h0)
		`CHK(hold_o, 4'h0)
		t_extremes();
		t_pointer();
		end_sim();
	end
endmodule : test_four_channel_sampling_sequencer

`default_nettype wire
